// >>> design/frps_sequencer.sv
// Purpose: State machine core sequencing three regulators from four rail comparators
// Assumes: Comparator results arrive asynchronously; single 50 MHz clock
// Notes:   Outputs are drive levels only; open-drain stage lives outside
//
// Overview of operation
// - Main rail high for 190 ms in reset moves to first-on, enabling regulator A.
// - In first-on, rail B qualified high moves to second-on, enabling regulator B.
// - In second-on, rail C qualified high moves to all-on, enabling regulator C.
// - In all-on, all four rails high moves to power-good, asserting power good.
// - In power-good, power good drops whenever any rail input falls low.
// - In power-good, main rail low drops all enables; other rails never do.
// - All enables and power good are low in reset and from start-up.
// - All outputs are active high assert/deassert levels.
// - Four rails monitored, three regulators in fixed order, power good last.
// - Power good waits 190 ms with all inputs high.
// - Rails B and C must hold high with earlier rails for 30 us to advance.
// - Rail B, C or D low for 30 us in power-good returns to all-on.
// - Main rail fault in power-good turns all enables off at once.
`timescale 1ns/1ps
module frps_sequencer #(
    parameter int unsigned LONG_CYC = frps_pkg::LONG_DLY_CYC
) (
    // Clock, reset and enable
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       clk_en_in,
    // Comparator results
    input  wire logic       main_rail_in,
    input  wire logic       rail_b_in,
    input  wire logic       rail_c_in,
    input  wire logic       rail_d_in,
    // Regulator enables and power good
    output logic            reg_a_enable_out,
    output logic            reg_b_enable_out,
    output logic            reg_c_enable_out,
    output logic            power_good_out
);
    // Terminal counts; the long one follows the parameter so a bench can shorten it
    localparam logic [frps_pkg::CNT_W-1:0] LONG_TC =
        frps_pkg::CNT_W'(LONG_CYC - 1);
    localparam logic [frps_pkg::CNT_W-1:0] QUAL_TC =
        frps_pkg::CNT_W'(frps_pkg::QUAL_DLY_CYC - 1);

    frps_pkg::frps_regs_t st_r;
    frps_pkg::frps_regs_t st_nxt;
    logic [3:0]           rails;

    assign rails = st_r.sync2; // bit0 main, 1 B, 2 C, 3 D

    // Next-state logic; counter restarts whenever the watched condition breaks
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = {rail_d_in, rail_c_in, rail_b_in, main_rail_in};
        st_nxt.sync2 = st_r.sync1;
        unique case (st_r.state)
            // Any low main sample throws the long count away
            frps_pkg::st_reset: begin
                if (!rails[0]) begin
                    st_nxt.cnt = frps_pkg::CNT_RST;
                end else if (st_r.cnt == LONG_TC) begin
                    st_nxt.cnt   = frps_pkg::CNT_RST;
                    st_nxt.state = frps_pkg::st_first_on;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            // Rail B has to hold together with the main rail
            frps_pkg::st_first_on: begin
                if (rails[1:0] != 2'h3) begin
                    st_nxt.cnt = frps_pkg::CNT_RST;
                end else if (st_r.cnt == QUAL_TC) begin
                    st_nxt.cnt   = frps_pkg::CNT_RST;
                    st_nxt.state = frps_pkg::st_second_on;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            // Rail C has to hold together with both earlier rails
            frps_pkg::st_second_on: begin
                if (rails[2:0] != 3'h7) begin
                    st_nxt.cnt = frps_pkg::CNT_RST;
                end else if (st_r.cnt == QUAL_TC) begin
                    st_nxt.cnt   = frps_pkg::CNT_RST;
                    st_nxt.state = frps_pkg::st_all_on;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            // All four high for the long delay before power good
            frps_pkg::st_all_on: begin
                if (rails != 4'hf) begin
                    st_nxt.cnt = frps_pkg::CNT_RST;
                end else if (st_r.cnt == LONG_TC) begin
                    st_nxt.cnt   = frps_pkg::CNT_RST;
                    st_nxt.state = frps_pkg::st_power_good;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            frps_pkg::st_power_good: begin
                // Main rail loss wins over everything: back to reset at once
                if (!rails[0]) begin
                    st_nxt.cnt   = frps_pkg::CNT_RST;
                    st_nxt.state = frps_pkg::st_reset;
                end else if (rails[3:1] == 3'h7) begin
                    // Secondaries all back: the fall-back window starts over
                    st_nxt.cnt = frps_pkg::CNT_RST;
                end else if (st_r.cnt == QUAL_TC) begin
                    st_nxt.cnt   = frps_pkg::CNT_RST;
                    st_nxt.state = frps_pkg::st_all_on;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            // Illegal codes go to reset, the safe state with every output low
            default: begin
                st_nxt.cnt   = frps_pkg::CNT_RST;
                st_nxt.state = frps_pkg::st_reset;
            end
        endcase
        // Outputs decoded from next state so they change with the state edge
        st_nxt.outs.reg_a_enable = (st_nxt.state != frps_pkg::st_reset);
        st_nxt.outs.reg_b_enable = (st_nxt.state == frps_pkg::st_second_on) ||
                                   (st_nxt.state == frps_pkg::st_all_on) ||
                                   (st_nxt.state == frps_pkg::st_power_good);
        st_nxt.outs.reg_c_enable = (st_nxt.state == frps_pkg::st_all_on) ||
                                   (st_nxt.state == frps_pkg::st_power_good);
        // Power good also drops on the first low sample, ahead of the 30 us return
        st_nxt.outs.power_good = (st_nxt.state == frps_pkg::st_power_good) &&
                                 (rails == 4'hf);
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_r.sync1 <= frps_pkg::RAILS_RST;
            st_r.sync2 <= frps_pkg::RAILS_RST;
            st_r.state <= frps_pkg::st_reset;
            st_r.cnt   <= frps_pkg::CNT_RST;
            st_r.outs  <= '0;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    // Plain active-high levels; open-drain conversion is external
    assign reg_a_enable_out = st_r.outs.reg_a_enable;
    assign reg_b_enable_out = st_r.outs.reg_b_enable;
    assign reg_c_enable_out = st_r.outs.reg_c_enable;
    assign power_good_out   = st_r.outs.power_good;

    // Assertions
    out_order_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (power_good_out |-> reg_c_enable_out) and (reg_c_enable_out |-> reg_b_enable_out)
        and (reg_b_enable_out |-> reg_a_enable_out))
        else $error("enable order broken");
    pg_drop_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (clk_en_in && st_r.state == frps_pkg::st_power_good && rails != 4'hf)
        |=> !power_good_out)
        else $error("power good held with a rail low");
    main_off_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (clk_en_in && st_r.state == frps_pkg::st_power_good && !rails[0])
        |=> !reg_a_enable_out && !reg_b_enable_out && !reg_c_enable_out)
        else $error("enables kept after main rail fault");
    other_keep_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r.state == frps_pkg::st_power_good && rails[0]) |=> reg_c_enable_out)
        else $error("enables dropped on secondary fault");
    first_on_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(reg_a_enable_out) |-> $past(st_r.cnt) == LONG_TC)
        else $error("regulator A enabled without full delay");
    b_qual_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(reg_b_enable_out) |-> $past(st_r.cnt) == QUAL_TC && $past(rails[1]))
        else $error("regulator B enabled without qualification");
    c_qual_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(reg_c_enable_out) |-> $past(st_r.cnt) == QUAL_TC && $past(rails[2]))
        else $error("regulator C enabled without qualification");
    pg_rise_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(power_good_out) && $past(st_r.state) == frps_pkg::st_all_on
        |-> $past(st_r.cnt) == LONG_TC)
        else $error("power good without full delay");
    rst_low_a: assert property (@(posedge clk_sys_in)
        sys_rst_in |=> !reg_a_enable_out && !reg_b_enable_out
        && !reg_c_enable_out && !power_good_out)
        else $error("outputs not low after reset");
    rst_state_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        st_r.state == frps_pkg::st_reset |-> !reg_a_enable_out && !reg_b_enable_out
        && !reg_c_enable_out && !power_good_out)
        else $error("output raised in reset state");

    // A broken main rail sample must restart the long count, not pause it
    main_restart_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (clk_en_in && st_r.state == frps_pkg::st_reset && !rails[0])
        |=> st_r.cnt == frps_pkg::CNT_RST)
        else $error("long count kept across a main rail drop");
    prior_rails_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ($rose(reg_b_enable_out) |-> $past(rails[1:0]) == 2'h3)
        and ($rose(reg_c_enable_out) |-> $past(rails[2:0]) == 3'h7))
        else $error("enable raised without earlier rails high");
    pg_rise_all_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(power_good_out) |-> $past(rails) == 4'hf)
        else $error("power good raised with a rail low");

    // Secondary loss held for the full window falls back with enables kept on
    pg_retreat_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (clk_en_in && st_r.state == frps_pkg::st_power_good && rails[0]
         && rails[3:1] != 3'h7 && st_r.cnt == QUAL_TC)
        |=> st_r.state == frps_pkg::st_all_on && reg_a_enable_out
        && reg_b_enable_out && reg_c_enable_out)
        else $error("no fall back to all-on after secondary loss");
    pg_early_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ($past(st_r.state) == frps_pkg::st_power_good && st_r.state == frps_pkg::st_all_on)
        |-> $past(st_r.cnt) == QUAL_TC)
        else $error("fell back before the qualify window");

    // Clock enable low must freeze synchronisers, state and counters alike
    en_freeze_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (!clk_en_in && !sys_rst_in) |=> $stable(st_r))
        else $error("state moved while clock enable low");
    sync_pipe_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (clk_en_in && !sys_rst_in) |=> st_r.sync2 == $past(st_r.sync1))
        else $error("synchroniser stage skipped");
endmodule // frps_sequencer

// >>> include/frps_pkg.sv
// Purpose: Shared constants and types for the four rail power sequencer
// Assumes: 50 MHz system clock
// Notes:   Long delays are also top-level parameters so simulation can shorten them
package frps_pkg;
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned LONG_DLY_MS   = 190;
    localparam int unsigned QUAL_DLY_US   = 30;
    localparam int unsigned LONG_DLY_CYC  = (CLK_HZ / 1000) * LONG_DLY_MS;
    localparam int unsigned QUAL_DLY_CYC  = (CLK_HZ / 1000000) * QUAL_DLY_US;
    localparam int          CNT_W         = 24;
    localparam logic [3:0]  RAILS_RST     = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST  = 24'h000000;

    typedef enum logic [2:0] {
        st_reset,
        st_first_on,
        st_second_on,
        st_all_on,
        st_power_good
    } frps_state_t;

    // Enable and power-good levels, active high
    typedef struct packed {
        logic reg_a_enable;
        logic reg_b_enable;
        logic reg_c_enable;
        logic power_good;
    } frps_outs_t;

    typedef struct packed {
        logic [3:0]       sync1;
        logic [3:0]       sync2;
        frps_state_t      state;
        logic [CNT_W-1:0] cnt;
        frps_outs_t       outs;
    } frps_regs_t;
endpackage

// >>> bench/frps_rail_model.sv
// Purpose: Far-side rails, each powered by the regulator enable before it
// Assumes: Each rail settles DLY cycles after its enable rises
// Notes:   fault_in pulls a rail low to mimic a failed supply
`timescale 1ns/1ps
module frps_rail_model #(
    parameter int DLY = 10
) (
    // Clock
    input  wire logic       clk_sys_in,
    // Enables and injected faults, bit 2 is rail B
    input  wire logic [2:0] en_in,
    input  wire logic [2:0] fault_in,
    // Comparator results
    output logic      [2:0] rail_out
);
    int cnt_r [3];

    initial rail_out = 3'h0;

    // An unpowered rail reads low at once, so no stale high survives an enable drop
    always @(negedge clk_sys_in) begin
        for (int i = 0; i < 3; i++) begin
            cnt_r[i]    <= !en_in[i] ? 0 : (cnt_r[i] < DLY ? cnt_r[i] + 1 : DLY);
            rail_out[i] <= en_in[i] && (cnt_r[i] == DLY) && !fault_in[i];
        end
    end
endmodule // frps_rail_model

// >>> bench/four_rail_power_sequencer_tb.sv
// Purpose: Self-checking bench for the rail sequencer
// Assumes: Inputs driven at falling edge; long delay shortened to LONG cycles
// Notes:   Windows allow for the two-flop input synchroniser
`timescale 1ns/1ps
module four_rail_power_sequencer_tb;
    localparam int LONG = 40;
    localparam int DLY  = 10;
    localparam int QUAL = 1500;
    logic       clk_sys_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       main_rail  = 1'b0;
    logic       clk_en     = 1'b1;
    logic [2:0] fault      = 3'h0;
    logic [2:0] rails;
    logic       ra, rb, rc, pg;
    logic [3:0] outs;
    int         errors     = 0;
    int         n_checks   = 0;
    int         n;

    assign outs = {ra, rb, rc, pg};

    // 50 MHz clock
    initial forever #10 clk_sys_in = ~clk_sys_in;

    frps_sequencer #(.LONG_CYC(LONG)) uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en), .main_rail_in(main_rail), .rail_b_in(rails[2]),
        .rail_c_in(rails[1]), .rail_d_in(rails[0]), .reg_a_enable_out(ra),
        .reg_b_enable_out(rb), .reg_c_enable_out(rc), .power_good_out(pg));

    frps_rail_model #(.DLY(DLY)) far (.clk_sys_in(clk_sys_in), .en_in({ra, rb, rc}),
        .fault_in(fault), .rail_out(rails));

    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(string what, int lo, int hi, int got);
        n_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Bounded wait for one output bit; idx 3 is enable A, 0 is power good
    task automatic wait_out(int idx, logic lvl, int maxc, output int cyc);
        cyc = 0;
        while (outs[idx] !== lvl && cyc < maxc) begin
            @(negedge clk_sys_in);
            cyc++;
        end
    endtask

    task automatic t_reset();
        repeat (10) @(negedge clk_sys_in);
        chk("outs in reset", 4'h0, outs);
        sys_rst_in = 1'b0;
        repeat (60) @(negedge clk_sys_in);
        chk("outs idle main low", 4'h0, outs);
        $display("test reset done");
    endtask

    task automatic t_powerup();
        main_rail = 1'b1;
        wait_out(3, 1'b1, LONG + 50, n);
        chk_rng("main to reg_a", LONG, LONG + 6, n);
        chk("outs first on", 4'h8, outs);
        wait_out(2, 1'b1, QUAL + 100, n);
        chk_rng("reg_a to reg_b", DLY + QUAL, DLY + QUAL + 8, n);
        chk("outs second on", 4'hc, outs);
        wait_out(1, 1'b1, QUAL + 100, n);
        chk_rng("reg_b to reg_c", DLY + QUAL, DLY + QUAL + 8, n);
        chk("outs all on", 4'he, outs);
        wait_out(0, 1'b1, LONG + 100, n);
        chk_rng("reg_c to pg", DLY + LONG, DLY + LONG + 8, n);
        chk("outs power good", 4'hf, outs);
        $display("test powerup done");
    endtask

    task automatic t_minor();
        // Faults land on the model's next falling edge, never racing its sample
        fault <= 3'h1;
        repeat (5) @(negedge clk_sys_in);
        fault <= 3'h0;
        chk("outs glitch d", 4'he, outs);
        wait_out(0, 1'b1, 30, n);
        chk_rng("pg back after glitch", 1, 8, n);
        fault <= 3'h2;
        wait_out(0, 1'b0, 8, n);
        chk_rng("rail_c loss to pg drop", 1, 5, n);
        repeat (QUAL + 20) @(negedge clk_sys_in);
        chk("outs after long c loss", 4'he, outs);
        fault <= 3'h0;
        wait_out(0, 1'b1, LONG + 50, n);
        chk_rng("pg requalify", LONG, LONG + 8, n);
        $display("test minor fault done");
    endtask

    task automatic t_main();
        main_rail = 1'b0;
        wait_out(3, 1'b0, 8, n);
        chk_rng("main loss to off", 1, 5, n);
        chk("outs after main loss", 4'h0, outs);
        main_rail = 1'b1;
        // Freeze the count part way; reg_a must then come LONG - 8 cycles after thaw
        repeat (10) @(negedge clk_sys_in);
        clk_en = 1'b0;
        repeat (100) @(negedge clk_sys_in);
        chk("outs while frozen", 4'h0, outs);
        clk_en = 1'b1;
        wait_out(3, 1'b1, LONG + 50, n);
        chk_rng("restart reg_a after freeze", LONG - 10, LONG - 4, n);
        $display("test main fault done");
    endtask

    task automatic t_midreset();
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        chk("outs in mid reset", 4'h0, outs);
        sys_rst_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk("outs after mid reset", 4'h0, outs);
        wait_out(3, 1'b1, LONG + 50, n);
        chk_rng("reg_a after mid reset", LONG - 3, LONG + 3, n);
        $display("test mid reset done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog, about eight times the expected run of some 5000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys_in);
        errors++;
        end_sim();
    end

    initial begin
        t_reset();
        t_powerup();
        t_minor();
        t_main();
        t_midreset();
        end_sim();
    end
endmodule // four_rail_power_sequencer_tb
